// ===== shared/regulator_set_a_pkg.sv
package regulator_set_a_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFFSET_CORE1_BUCK   = 8'ha4;
  localparam logic [7:0] OFFSET_PROC_BUCK    = 8'ha5;
  localparam logic [7:0] OFFSET_MEM_BUCK     = 8'ha6;
  localparam logic [7:0] OFFSET_IO_BUCK      = 8'ha7;
  localparam logic [7:0] OFFSET_PERI_BUCK    = 8'ha8;
  localparam logic [7:0] OFFSET_LINEAR_THREE = 8'hab;
  localparam logic [7:0] OFFSET_LINEAR_SEVEN = 8'haf;
  localparam logic [7:0] OFFSET_LINEAR_EIGHT = 8'hb0;
  localparam logic [7:0] OFFSET_LINEAR_NINE  = 8'hb1;
  localparam logic [7:0] OFFSET_LINEAR_ELEV  = 8'hb3;

  localparam int REG_COUNT   = 10;
  localparam int DEC_COUNT   = 9;
  localparam int BUCK_COUNT  = 5;
  localparam int LDO_COUNT   = 4;

  localparam logic [3:0] IDX_CORE1   = 4'h0;
  localparam logic [3:0] IDX_PROC    = 4'h1;
  localparam logic [3:0] IDX_MEM     = 4'h2;
  localparam logic [3:0] IDX_IO      = 4'h3;
  localparam logic [3:0] IDX_PERI    = 4'h4;
  localparam logic [3:0] IDX_LDO3    = 4'h5;
  localparam logic [3:0] IDX_LDO7    = 4'h6;
  localparam logic [3:0] IDX_LDO8    = 4'h7;
  localparam logic [3:0] IDX_LDO9    = 4'h8;
  localparam logic [3:0] IDX_LDO11   = 4'h9;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int SLEEP_BIT        = 7;
  localparam logic [6:0] WIDE_CODE_MASK  = 7'h7f;
  localparam logic [6:0] NARROW_CODE_MASK = 7'h3f;
  localparam logic [7:0] RESET_DEFAULT    = 8'h00;
  localparam logic [7:0] RESET_LINEAR_NINE = 8'h01;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;
  localparam logic [1:0] MODE_PER_SET     = 2'h0;
  localparam logic [1:0] MODE_SLEEP       = 2'h1;
  localparam logic [1:0] MODE_SYNC        = 2'h2;
  localparam logic [1:0] MODE_AUTO        = 2'h3;

  // ----------------------------------------------------------------
  // Voltage decode, levels and steps in mV
  // ----------------------------------------------------------------
  localparam logic [11:0] CORE_BASE_MV   = 12'h12c;  // 300
  localparam logic [11:0] PROC_BASE_MV   = 12'h212;  // 530
  localparam logic [11:0] WIDE_BASE_MV   = 12'h320;  // 800
  localparam logic [11:0] LDO3_BASE_MV   = 12'h384;  // 900
  localparam logic [11:0] LDO78_BASE_MV  = 12'h384;  // 900
  localparam logic [11:0] LDO9_BASE_MV   = 12'h3b6;  // 950
  localparam logic [11:0] LDO_TOP_MV     = 12'he10;  // 3600
  localparam logic [11:0] STEP_10_MV     = 12'h00a;
  localparam logic [11:0] STEP_20_MV     = 12'h014;
  localparam logic [11:0] STEP_50_MV     = 12'h032;
  localparam logic [6:0]  LDO78_FLAT_TOP = 7'h02;
  localparam logic [6:0]  LDO78_SAT_CODE = 7'h38;
  localparam logic [6:0]  LDO9_FIRST     = 7'h01;
  localparam logic [6:0]  LDO9_SAT_CODE  = 7'h38;

  typedef enum logic [5:0] {
    KIND_CORE  = 6'b000001,
    KIND_PROC  = 6'b000010,
    KIND_WIDE  = 6'b000100,
    KIND_LDO3  = 6'b001000,
    KIND_LDO78 = 6'b010000,
    KIND_LDO9  = 6'b100000
  } code_kind_t;

  typedef enum logic [3:0] {
    OP_UNSET = 4'b0001,
    OP_SLEEP = 4'b0010,
    OP_SYNC  = 4'b0100,
    OP_AUTO  = 4'b1000
  } buck_op_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    buck_op_t    op;
    logic [11:0] mv;
  } buck_status_t;

  typedef struct packed {
    logic        sleep;
    logic        half_current;
    logic [11:0] mv;
  } ldo_status_t;

endpackage : regulator_set_a_pkg

// ===== rtl/voltage_code_decoder.sv
`timescale 1ns/1ps

module voltage_code_decoder
(
  input  wire regulator_set_a_pkg::code_kind_t kind,  // Encoding family
  input  wire logic [6:0]                      code,  // Masked voltage code
  output logic [11:0]                          mv     // Target in mV
);

  // ----------------------------------------------------------------
  // Linear code arithmetic
  // ----------------------------------------------------------------
  function automatic logic [11:0] linear_mv(input logic [11:0] base,
                                            input logic [11:0] step,
                                            input logic [6:0]  steps);
    linear_mv = base + 12'(12'(steps) * step);
  endfunction : linear_mv

  always_comb
  begin
    case (kind)
      regulator_set_a_pkg::KIND_CORE:
        mv = linear_mv(regulator_set_a_pkg::CORE_BASE_MV, regulator_set_a_pkg::STEP_10_MV,
                       code);
      regulator_set_a_pkg::KIND_PROC:
        mv = linear_mv(regulator_set_a_pkg::PROC_BASE_MV, regulator_set_a_pkg::STEP_10_MV,
                       code);
      regulator_set_a_pkg::KIND_WIDE:
        mv = linear_mv(regulator_set_a_pkg::WIDE_BASE_MV, regulator_set_a_pkg::STEP_20_MV,
                       code);
      regulator_set_a_pkg::KIND_LDO3:
        mv = linear_mv(regulator_set_a_pkg::LDO3_BASE_MV, regulator_set_a_pkg::STEP_20_MV,
                       code);
      regulator_set_a_pkg::KIND_LDO78:
      begin
        if (code <= regulator_set_a_pkg::LDO78_FLAT_TOP)
          mv = regulator_set_a_pkg::LDO78_BASE_MV;
        else if (code >= regulator_set_a_pkg::LDO78_SAT_CODE)
          mv = regulator_set_a_pkg::LDO_TOP_MV;
        else
          mv = linear_mv(regulator_set_a_pkg::LDO78_BASE_MV, regulator_set_a_pkg::STEP_50_MV,
                         code - regulator_set_a_pkg::LDO78_FLAT_TOP);
      end
      regulator_set_a_pkg::KIND_LDO9:
      begin
        // Same ladder as the 6-bit pair, floored; forbidden code zero lands on the floor
        if (code <= regulator_set_a_pkg::LDO78_FLAT_TOP)
          mv = regulator_set_a_pkg::LDO9_BASE_MV;
        else if (code >= regulator_set_a_pkg::LDO9_SAT_CODE)
          mv = regulator_set_a_pkg::LDO_TOP_MV;
        else
          mv = linear_mv(regulator_set_a_pkg::LDO78_BASE_MV, regulator_set_a_pkg::STEP_50_MV,
                         code - regulator_set_a_pkg::LDO78_FLAT_TOP);
      end
      default:
        mv = regulator_set_a_pkg::CORE_BASE_MV;
    endcase
  end

endmodule : voltage_code_decoder

// ===== rtl/regulator_set_a_voltage_regs.sv
`timescale 1ns/1ps

module regulator_set_a_voltage_regs
(
  input  wire logic                                  clk,            // 100 MHz clock
  input  wire logic                                  reset,          // Sync reset, high
  input  wire regulator_set_a_pkg::reg_req_t         reg_req,        // Register access
  output logic [7:0]                                 reg_rdata,      // Read data
  output logic                                       reg_rvalid,     // Read data valid
  output logic                                       reg_unmapped,   // Last access missed
  input  wire logic                                  set_a_selected, // A set in use
  input  wire logic [4:0][1:0]                       buck_mode,      // Buck mode fields
  output regulator_set_a_pkg::buck_status_t [4:0]    buck_status,    // Buck operation
  output regulator_set_a_pkg::ldo_status_t [3:0]     ldo_status,     // LDO3,7,8,9
  output logic                                       ldo11_sleep,    // LDO11 sleep
  output logic                                       ldo11_half,     // LDO11 half-current
  output logic                                       ldo9_code_fault // LDO9 code zero held
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       hit;
    logic [3:0] idx;
  } decode_t;

  function automatic decode_t decode_addr(input logic [7:0] addr);
    decode_t d;
    d.hit = 1'b1;
    d.idx = regulator_set_a_pkg::IDX_CORE1;
    case (addr)
      regulator_set_a_pkg::OFFSET_CORE1_BUCK:   d.idx = regulator_set_a_pkg::IDX_CORE1;
      regulator_set_a_pkg::OFFSET_PROC_BUCK:    d.idx = regulator_set_a_pkg::IDX_PROC;
      regulator_set_a_pkg::OFFSET_MEM_BUCK:     d.idx = regulator_set_a_pkg::IDX_MEM;
      regulator_set_a_pkg::OFFSET_IO_BUCK:      d.idx = regulator_set_a_pkg::IDX_IO;
      regulator_set_a_pkg::OFFSET_PERI_BUCK:    d.idx = regulator_set_a_pkg::IDX_PERI;
      regulator_set_a_pkg::OFFSET_LINEAR_THREE: d.idx = regulator_set_a_pkg::IDX_LDO3;
      regulator_set_a_pkg::OFFSET_LINEAR_SEVEN: d.idx = regulator_set_a_pkg::IDX_LDO7;
      regulator_set_a_pkg::OFFSET_LINEAR_EIGHT: d.idx = regulator_set_a_pkg::IDX_LDO8;
      regulator_set_a_pkg::OFFSET_LINEAR_NINE:  d.idx = regulator_set_a_pkg::IDX_LDO9;
      regulator_set_a_pkg::OFFSET_LINEAR_ELEV:  d.idx = regulator_set_a_pkg::IDX_LDO11;
      default:                                  d.hit = 1'b0;
    endcase
    return d;
  endfunction : decode_addr

  function automatic logic [7:0] reset_value(input int idx);
    if (idx == int'(regulator_set_a_pkg::IDX_LDO9))
      reset_value = regulator_set_a_pkg::RESET_LINEAR_NINE;
    else
      reset_value = regulator_set_a_pkg::RESET_DEFAULT;
  endfunction : reset_value

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  localparam int SLEEP_POS = regulator_set_a_pkg::SLEEP_BIT;
  logic [7:0] regs [regulator_set_a_pkg::REG_COUNT];
  decode_t    req_dec;

  assign req_dec = decode_addr(reg_req.addr);

  // Whole bytes are stored, reserved bits included, so they read back as written
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < regulator_set_a_pkg::REG_COUNT; i++)
        regs[i] <= reset_value(i);
    end
    else if (reg_req.write && req_dec.hit)
    begin
      regs[req_dec.idx] <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata  <= regulator_set_a_pkg::READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.read;
      if (reg_req.read)
        reg_rdata <= req_dec.hit ? regs[req_dec.idx] : regulator_set_a_pkg::READ_UNMAPPED;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      reg_unmapped <= 1'b0;
    else if (reg_req.read || reg_req.write)
      reg_unmapped <= !req_dec.hit;
  end

  // ----------------------------------------------------------------
  // Voltage code decode
  // ----------------------------------------------------------------
  function automatic regulator_set_a_pkg::code_kind_t kind_of(input int idx);
    case (idx)
      0:       kind_of = regulator_set_a_pkg::KIND_CORE;
      1:       kind_of = regulator_set_a_pkg::KIND_PROC;
      2, 3, 4: kind_of = regulator_set_a_pkg::KIND_WIDE;
      5:       kind_of = regulator_set_a_pkg::KIND_LDO3;
      6, 7:    kind_of = regulator_set_a_pkg::KIND_LDO78;
      default: kind_of = regulator_set_a_pkg::KIND_LDO9;
    endcase
  endfunction : kind_of

  // Six-bit fields drop the reserved bit 6 before decoding
  function automatic logic [6:0] code_of(input int idx, input logic [7:0] value);
    if (idx > int'(regulator_set_a_pkg::IDX_LDO3))
      code_of = value[6:0] & regulator_set_a_pkg::NARROW_CODE_MASK;
    else
      code_of = value[6:0] & regulator_set_a_pkg::WIDE_CODE_MASK;
  endfunction : code_of

  logic [11:0] next_mv [regulator_set_a_pkg::DEC_COUNT];

  for (genvar g = 0; g < regulator_set_a_pkg::DEC_COUNT; g++)
  begin : g_dec
    voltage_code_decoder i_voltage_code_decoder
    (
      .kind (kind_of(g)),
      .code (code_of(g, regs[g])),
      .mv   (next_mv[g])
    );
  end

  // ----------------------------------------------------------------
  // Buck operating mode
  // ----------------------------------------------------------------
  function automatic regulator_set_a_pkg::buck_op_t buck_op(input logic [1:0] mode,
                                                           input logic       sleep_sel,
                                                           input logic       a_sel);
    case (mode)
      regulator_set_a_pkg::MODE_PER_SET:
        if (!a_sel)
          buck_op = regulator_set_a_pkg::OP_UNSET;
        else if (sleep_sel)
          buck_op = regulator_set_a_pkg::OP_SLEEP;
        else
          buck_op = regulator_set_a_pkg::OP_SYNC;
      regulator_set_a_pkg::MODE_SLEEP: buck_op = regulator_set_a_pkg::OP_SLEEP;
      regulator_set_a_pkg::MODE_SYNC:  buck_op = regulator_set_a_pkg::OP_SYNC;
      regulator_set_a_pkg::MODE_AUTO:  buck_op = regulator_set_a_pkg::OP_AUTO;
      default:                         buck_op = regulator_set_a_pkg::OP_UNSET;
    endcase
  endfunction : buck_op

  logic core1_buck_sleep_sel_a;
  logic processor_buck_sleep_sel_a;
  logic memory_buck_sleep_sel_a;
  logic io_buck_sleep_sel_a;
  logic peripheral_buck_sleep_sel_a;
  logic [4:0] buck_sleep_sel;

  assign core1_buck_sleep_sel_a      = regs[regulator_set_a_pkg::IDX_CORE1][SLEEP_POS];
  assign processor_buck_sleep_sel_a  = regs[regulator_set_a_pkg::IDX_PROC][SLEEP_POS];
  assign memory_buck_sleep_sel_a     = regs[regulator_set_a_pkg::IDX_MEM][SLEEP_POS];
  assign io_buck_sleep_sel_a         = regs[regulator_set_a_pkg::IDX_IO][SLEEP_POS];
  assign peripheral_buck_sleep_sel_a = regs[regulator_set_a_pkg::IDX_PERI][SLEEP_POS];
  assign buck_sleep_sel = {peripheral_buck_sleep_sel_a, io_buck_sleep_sel_a,
                           memory_buck_sleep_sel_a, processor_buck_sleep_sel_a,
                           core1_buck_sleep_sel_a};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int b = 0; b < regulator_set_a_pkg::BUCK_COUNT; b++)
      begin
        buck_status[b].op <= regulator_set_a_pkg::OP_UNSET;
        buck_status[b].mv <= regulator_set_a_pkg::CORE_BASE_MV;
      end
    end
    else
    begin
      buck_status[0].op <= buck_op(buck_mode[0], buck_sleep_sel[0], set_a_selected);
      buck_status[1].op <= buck_op(buck_mode[1], buck_sleep_sel[1], set_a_selected);
      buck_status[2].op <= buck_op(buck_mode[2], buck_sleep_sel[2], set_a_selected);
      buck_status[3].op <= buck_op(buck_mode[3], buck_sleep_sel[3], set_a_selected);
      buck_status[4].op <= buck_op(buck_mode[4], buck_sleep_sel[4], set_a_selected);
      for (int b = 0; b < regulator_set_a_pkg::BUCK_COUNT; b++)
        buck_status[b].mv <= next_mv[b];
    end
  end

  // ----------------------------------------------------------------
  // Linear regulator controls
  // ----------------------------------------------------------------
  logic linear_three_sleep_sel_a;
  logic linear_seven_sleep_sel_a;
  logic linear_eight_sleep_sel_a;
  logic linear_nine_sleep_sel_a;
  logic linear_eleven_sleep_sel_a;
  logic [3:0] ldo_sleep_sel;

  assign linear_three_sleep_sel_a  = regs[regulator_set_a_pkg::IDX_LDO3][SLEEP_POS];
  assign linear_seven_sleep_sel_a  = regs[regulator_set_a_pkg::IDX_LDO7][SLEEP_POS];
  assign linear_eight_sleep_sel_a  = regs[regulator_set_a_pkg::IDX_LDO8][SLEEP_POS];
  assign linear_nine_sleep_sel_a   = regs[regulator_set_a_pkg::IDX_LDO9][SLEEP_POS];
  assign linear_eleven_sleep_sel_a = regs[regulator_set_a_pkg::IDX_LDO11][SLEEP_POS];
  assign ldo_sleep_sel = {linear_nine_sleep_sel_a, linear_eight_sleep_sel_a,
                          linear_seven_sleep_sel_a, linear_three_sleep_sel_a};

  // Controls apply only while set A is in use; otherwise both stay low
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int l = 0; l < regulator_set_a_pkg::LDO_COUNT; l++)
      begin
        ldo_status[l].sleep        <= 1'b0;
        ldo_status[l].half_current <= 1'b0;
        ldo_status[l].mv           <= regulator_set_a_pkg::LDO3_BASE_MV;
      end
      ldo11_sleep <= 1'b0;
      ldo11_half  <= 1'b0;
    end
    else
    begin
      for (int l = 0; l < regulator_set_a_pkg::LDO_COUNT; l++)
      begin
        ldo_status[l].sleep        <= set_a_selected && ldo_sleep_sel[l];
        ldo_status[l].half_current <= set_a_selected && !ldo_sleep_sel[l];
        ldo_status[l].mv           <= next_mv[regulator_set_a_pkg::BUCK_COUNT + l];
      end
      ldo11_sleep <= set_a_selected && linear_eleven_sleep_sel_a;
      ldo11_half  <= set_a_selected && !linear_eleven_sleep_sel_a;
    end
  end

  // Flags a forbidden code zero; the decoder clamps it to the lowest step meanwhile
  always_ff @(posedge clk)
  begin
    if (reset)
      ldo9_code_fault <= 1'b0;
    else
      ldo9_code_fault <= (code_of(int'(regulator_set_a_pkg::IDX_LDO9),
                                  regs[regulator_set_a_pkg::IDX_LDO9]) == 7'h00);
  end

endmodule : regulator_set_a_voltage_regs

// ===== dv/regulator_set_a_props.sv
`timescale 1ns/1ps

module regulator_set_a_props
(
  input wire logic                                     clk,             // Clock
  input wire logic                                     reset,           // Sync reset
  input wire regulator_set_a_pkg::reg_req_t            reg_req,         // Register access
  input wire logic [7:0]                               reg_rdata,       // Read data
  input wire logic                                     reg_rvalid,      // Read valid
  input wire logic                                     reg_unmapped,    // Miss flag
  input wire logic                                     set_a_selected,  // A set in use
  input wire logic [4:0][1:0]                          buck_mode,       // Buck modes
  input wire regulator_set_a_pkg::buck_status_t [4:0]  buck_status,     // Buck state
  input wire regulator_set_a_pkg::ldo_status_t [3:0]   ldo_status,      // LDO state
  input wire logic                                     ldo11_sleep,     // LDO11 sleep
  input wire logic                                     ldo11_half,      // LDO11 half
  input wire logic                                     ldo9_code_fault  // LDO9 zero code
);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  localparam regulator_set_a_pkg::buck_op_t FORCED [4] = '{regulator_set_a_pkg::OP_UNSET,
    regulator_set_a_pkg::OP_SLEEP, regulator_set_a_pkg::OP_SYNC, regulator_set_a_pkg::OP_AUTO};
  logic [1:0] since_rst;
  logic [4:0] ldo_sl;
  logic [4:0] ldo_hc;
  assign ldo_sl = {ldo11_sleep, ldo_status[3].sleep, ldo_status[2].sleep,
                   ldo_status[1].sleep, ldo_status[0].sleep};
  assign ldo_hc = {ldo11_half, ldo_status[3].half_current, ldo_status[2].half_current,
                   ldo_status[1].half_current, ldo_status[0].half_current};

  // Decoded outputs carry reset contents for a couple of edges, so value checks wait
  always_ff @(posedge clk)
  begin
    if (reset)
      since_rst <= 2'h0;
    else if (since_rst != 2'h3)
      since_rst <= since_rst + 2'h1;
  end

  function automatic logic mapped(input logic [7:0] a);
    return a inside {[8'ha4:8'ha8], 8'hab, regulator_set_a_pkg::OFFSET_LINEAR_SEVEN,
                     8'hb0, 8'hb1, 8'hb3};
  endfunction : mapped

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // --------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------
  a_read_valid_pulse:
    assert property (reg_req.read |=> reg_rvalid) else $error("read gave no valid");
  a_no_spurious_valid:
    assert property (!reg_req.read |=> !reg_rvalid) else $error("valid without read");
  a_rdata_holds:
    assert property (!reg_req.read |=> $stable(reg_rdata)) else $error("rdata moved");
  a_unmapped_read_zero:
    assert property (reg_req.read && !mapped(reg_req.addr) |=> reg_unmapped && reg_rdata == 8'h00)
      else $error("unmapped read wrong");
  a_mapped_hit_clear:
    assert property ((reg_req.read || reg_req.write) && mapped(reg_req.addr) |=> !reg_unmapped)
      else $error("mapped access flagged");
  a_write_read_back:
    assert property (reg_req.write && mapped(reg_req.addr) ##1 reg_req.read && !reg_req.write
      && reg_req.addr == $past(reg_req.addr) |=> reg_rdata == $past(reg_req.wdata, 2))
      else $error("readback differs from write");

  // --------------------------------------------------------------
  // Decoded operation
  // --------------------------------------------------------------
  for (genvar b = 0; b < 5; b++)
  begin : g_buck
    a_forced_mode_op:
      assert property (since_rst == 2'h3 && buck_mode[b] != 2'h0
        |=> buck_status[b].op == FORCED[$past(buck_mode[b])]) else $error("forced mode op");
    a_per_set_two_way:
      assert property (since_rst == 2'h3 && set_a_selected && buck_mode[b] == 2'h0
        |=> buck_status[b].op inside {regulator_set_a_pkg::OP_SLEEP,
        regulator_set_a_pkg::OP_SYNC})
        else $error("per-set op");
    a_unset_off_a:
      assert property (since_rst == 2'h3 && !set_a_selected && buck_mode[b] == 2'h0
        |=> buck_status[b].op == regulator_set_a_pkg::OP_UNSET) else $error("op not unset");
  end
  for (genvar l = 0; l < 5; l++)
  begin : g_ldo
    a_ldo_one_mode:
      assert property (since_rst == 2'h3 |=> (ldo_sl[l] | ldo_hc[l]) == $past(set_a_selected)
        && !(ldo_sl[l] && ldo_hc[l])) else $error("ldo mode pair");
  end
  a_fault_clamps_mv:
    assert property (since_rst == 2'h3 && ldo9_code_fault
      |-> ldo_status[3].mv == regulator_set_a_pkg::LDO9_BASE_MV) else $error("fault mv");

  c_unmapped_read: cover property (reg_req.read && !mapped(reg_req.addr));
  c_fault_seen: cover property (ldo9_code_fault);
  c_auto_op: cover property (buck_status[0].op == regulator_set_a_pkg::OP_AUTO);
endmodule : regulator_set_a_props

// ===== dv/regulator_set_a_voltage_regs_tb.sv
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module regulator_set_a_voltage_regs_tb;
  // --------------------------------------------------------------
  // Signals and tables
  // --------------------------------------------------------------
  logic                                    clk = 1'b0;
  logic                                    reset = 1'b1;
  regulator_set_a_pkg::reg_req_t           reg_req = '0;
  logic [7:0]                              reg_rdata;
  logic                                    reg_rvalid;
  logic                                    reg_unmapped;
  logic                                    set_a_selected = 1'b1;
  logic [4:0][1:0]                         buck_mode = '0;
  regulator_set_a_pkg::buck_status_t [4:0] buck_status;
  regulator_set_a_pkg::ldo_status_t [3:0]  ldo_status;
  logic                                    ldo11_sleep;
  logic                                    ldo11_half;
  logic                                    ldo9_code_fault;
  int                                      num_errors = 0;
  int                                      checked = 0;
  int                                      cycles = 0;
  logic [7:0]  regs [10] = '{8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'hab, 8'haf, 8'hb0, 8'hb1, 8'hb3};
  logic [7:0]  holes [6] = '{8'ha9, 8'haa, 8'hac, 8'had, 8'hae, 8'hb2};
  int          t_idx [18] = '{0, 0, 0, 1, 1, 2, 3, 4, 5, 5, 6, 6, 6, 6, 7, 8, 8, 8};
  logic [6:0]  t_code [18] = '{7'h00, 7'h05, 7'h7f, 7'h00, 7'h43, 7'h7f, 7'h14, 7'h32, 7'h00,
    7'h7f, 7'h02, 7'h03, 7'h38, 7'h3f, 7'h04, 7'h01, 7'h30, 7'h38};
  logic [11:0] t_mv [18] = '{12'h12c, 12'h15e, 12'h622, 12'h212, 12'h4b0, 12'hd0c, 12'h4b0,
    12'h708, 12'h384, 12'hd70, 12'h384, 12'h3b6, 12'he10, 12'he10, 12'h3e8, 12'h3b6, 12'hc80,
    12'he10};
  regulator_set_a_pkg::buck_op_t exp_op [4] = '{regulator_set_a_pkg::OP_UNSET,
    regulator_set_a_pkg::OP_SLEEP, regulator_set_a_pkg::OP_SYNC, regulator_set_a_pkg::OP_AUTO};

  regulator_set_a_voltage_regs i_regulator_set_a_voltage_regs (.clk(clk), .reset(reset),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_unmapped(reg_unmapped), .set_a_selected(set_a_selected), .buck_mode(buck_mode),
    .buck_status(buck_status), .ldo_status(ldo_status), .ldo11_sleep(ldo11_sleep),
    .ldo11_half(ldo11_half), .ldo9_code_fault(ldo9_code_fault));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------
  task automatic req_go(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{write: w, read: r, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask : req_go

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req_go(1'b0, 1'b1, a, 8'h00);
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK("rdata", e, reg_rdata)
  endtask : rd

  // Decoded outputs land one edge after the write is taken; settle waits two
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [11:0] mv_of(input int i);
    return (i < 5) ? buck_status[i].mv : ldo_status[i - 5].mv;
  endfunction : mv_of

  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("CHECK FAILED timeout expected done seen running");
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd(regs[i], (i == 8) ? 8'h01 : 8'h00);
    settle();
    `CHK("proc mv", regulator_set_a_pkg::PROC_BASE_MV, buck_status[1].mv)
    for (int i = 0; i < 6; i++)
    begin
      req_go(1'b1, 1'b0, holes[i], 8'h5a);
      rd(holes[i], 8'h00);
      `CHK("unmapped", 1'b1, reg_unmapped)
    end
    for (int i = 0; i < 18; i++)
    begin
      req_go(1'b1, 1'b0, regs[t_idx[i]], {1'b0, t_code[i]});
      settle();
      `CHK("mv", t_mv[i], mv_of(t_idx[i]))
      rd(regs[t_idx[i]], {1'b0, t_code[i]});
      `CHK("mapped", 1'b0, reg_unmapped)
    end
    req_go(1'b1, 1'b0, 8'hb1, 8'h00);
    settle();
    `CHK("fault", 1'b1, ldo9_code_fault)
    `CHK("fault mv", regulator_set_a_pkg::LDO9_BASE_MV, ldo_status[3].mv)
    for (int i = 0; i < 10; i++)
      for (int s = 0; s < 2; s++)
      begin
        req_go(1'b1, 1'b0, regs[i], {s[0], 7'h05});
        settle();
        if (i < 5)
          `CHK("op", exp_op[s ? 1 : 2], buck_status[i].op)
        else if (i == 9)
          `CHK("ldo11", {s[0], !s[0]}, {ldo11_sleep, ldo11_half})
        else
          `CHK("ldo", {s[0], !s[0]},
               {ldo_status[i - 5].sleep, ldo_status[i - 5].half_current})
      end
    `CHK("fault gone", 1'b0, ldo9_code_fault)
    for (int m = 3; m >= 0; m--)
    begin
      @(posedge clk);
      buck_mode <= {5{m[1:0]}};
      settle();
      for (int b = 0; b < 5; b++)
        `CHK("mode op", exp_op[(m == 0) ? 1 : m], buck_status[b].op)
    end
    @(posedge clk);
    set_a_selected <= 1'b0;
    settle();
    `CHK("off a op", regulator_set_a_pkg::OP_UNSET, buck_status[4].op)
    `CHK("off a ldo", 2'b00, {ldo_status[0].sleep, ldo_status[0].half_current})
    // Back to back: a write, a write with a read of the old value, then a read
    @(posedge clk);
    reg_req <= '{write: 1'b1, read: 1'b0, addr: 8'ha6, wdata: 8'h3c};
    @(posedge clk);
    reg_req <= '{write: 1'b1, read: 1'b1, addr: 8'ha6, wdata: 8'h77};
    @(posedge clk);
    reg_req <= '{write: 1'b0, read: 1'b1, addr: 8'ha6, wdata: 8'h00};
    #1;
    `CHK("old data", 8'h3c, reg_rdata)
    @(posedge clk);
    reg_req <= '0;
    #1;
    `CHK("new data", 8'h77, reg_rdata)
    wrap_up();
  end
endmodule : regulator_set_a_voltage_regs_tb

bind regulator_set_a_voltage_regs regulator_set_a_props i_regulator_set_a_props (.clk(clk),
  .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reg_unmapped(reg_unmapped), .set_a_selected(set_a_selected), .buck_mode(buck_mode),
  .buck_status(buck_status), .ldo_status(ldo_status), .ldo11_sleep(ldo11_sleep),
  .ldo11_half(ldo11_half), .ldo9_code_fault(ldo9_code_fault));
